// ### rtl/uart_fc_pkg.sv
`default_nettype none
package uart_fc_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CONF     = 8'h00;
  localparam logic [7:0] OFF_CMD      = 8'h04;
  localparam logic [7:0] OFF_RX_THR   = 8'h08;
  localparam logic [7:0] OFF_TX_THR   = 8'h0c;
  localparam logic [7:0] OFF_XOFF_THR = 8'h10;
  localparam logic [7:0] OFF_CHARS    = 8'h14;
  localparam logic [7:0] OFF_TOUT     = 8'h18;
  localparam logic [7:0] OFF_STATUS   = 8'h1c;
  localparam logic [7:0] OFF_INT_RAW  = 8'h20;
  localparam logic [7:0] OFF_INT_ST   = 8'h24;
  localparam logic [7:0] OFF_INT_ENA  = 8'h28;
  localparam logic [7:0] OFF_INT_CLR  = 8'h2c;

  // configuration bit positions
  localparam int CONF_RX_FLOW_EN   = 0;
  localparam int CONF_SOFT_RTS     = 1;
  localparam int CONF_DTR          = 2;
  localparam int CONF_LOOPBACK     = 3;
  localparam int CONF_TX_FLOW_EN   = 4;
  localparam int CONF_SOFT_FLOW_EN = 5;
  localparam int CONF_RS485_EN     = 6;
  localparam int CONF_W            = 7;

  // command bit positions (write-only pulses)
  localparam int CMD_FORCE_OFF = 0;
  localparam int CMD_FORCE_ON  = 1;
  localparam int CMD_SEND_XOFF = 2;
  localparam int CMD_SEND_XON  = 3;

  // interrupt bit positions
  localparam int IRQ_ESCAPE      = 0;
  localparam int IRQ_COLLISION   = 1;
  localparam int IRQ_RS485_FRM   = 2;
  localparam int IRQ_RS485_PAR   = 3;
  localparam int IRQ_TX_DONE     = 4;
  localparam int IRQ_IDLE_GAP    = 5;
  localparam int IRQ_NULL_DONE   = 6;
  localparam int IRQ_START_BIT   = 7;
  localparam int IRQ_HALT_CHAR   = 8;
  localparam int IRQ_RESUME_CHAR = 9;
  localparam int IRQ_RX_TIMEOUT  = 10;
  localparam int IRQ_LINE_BREAK  = 11;
  localparam int IRQ_CTS_CHG     = 12;
  localparam int IRQ_DSR_CHG     = 13;
  localparam int IRQ_RX_OVF      = 14;
  localparam int IRQ_FRAME_ERR   = 15;
  localparam int IRQ_PARITY_ERR  = 16;
  localparam int IRQ_TX_LOW      = 17;
  localparam int IRQ_RX_HIGH     = 18;
  localparam int IRQ_N           = 19;

  // reset values
  localparam logic [CONF_W-1:0] CONF_RST     = 7'h00;
  localparam logic [9:0]        RX_THR_RST   = 10'h060;
  localparam logic [9:0]        TX_THR_RST   = 10'h010;
  localparam logic [7:0]        XOFF_THR_RST = 8'he0;
  localparam logic [31:0]       CHARS_RST    = 32'h032b_1311;
  localparam logic [15:0]       TOUT_RST     = 16'h0100;

endpackage : uart_fc_pkg
`default_nettype wire

// ### rtl/uart_flow_control_irq.sv
// Notes on behaviour
// [R01] rts_out high asks the far end for data, low tells it to halt.
// [R02] receive flow disabled: rts_out follows the software request level bit.
// [R03] receive flow enabled: rts_out drops once rx level exceeds rx_full_threshold.
// [R04] any clear-to-send edge raises its irq; with tx flow enabled, low cts stops transmit after current frame.
// [R05] any set-ready edge raises its irq; present level readable in status.
// [R06] dtr_out high says the transmit side has finished preparing data.
// [R07] loopback routes tx data to rx, rts to cts, dtr to dsr.
// [R08] force-off halts transmission; force-on resumes it.
// [R09] soft flow on: send halt char once received bytes exceed xoff threshold.
// [R10] soft flow on: requested halt or resume char goes after current frame.
// [R11] escape irq when the configured escape character run is received.
// [R12] rs485 mode: separate collision, frame error and parity error irqs.
// [R13] tx done irq once every transmit fifo word has been shifted out.
// [R14] irqs for minimum idle gap reached and for trailing null chars done.
// [R15] start bit seen irq whenever the receiver detects a start bit.
// [R16] soft flow on: irqs on reception of halt or resume characters.
// [R17] rx timeout irq when a byte takes longer than the timeout threshold.
// [R18] line break irq when the line is low after the stop bit.
// [R19] rx overflow irq when data arrives with the rx fifo full.
// [R20] frame error and parity error irqs for bad received frames.
// [R21] tx low irq while tx fifo level is below the empty threshold.
// [R22] rx high irq while rx level exceeds the combined full threshold fields.
// [R23] raw flags stay set until cleared; enable bits gate them onto irq.
`default_nettype none
module uart_flow_control_irq
  import uart_fc_pkg::*;
#(
  parameter int LEVEL_W = 10
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // serial pins
  input  wire logic               rxd_in,
  input  wire logic               cts_in,
  input  wire logic               dsr_in,
  output logic                    txd_out,
  output logic                    rts_out,
  output logic                    dtr_out,
  // transmitter side
  input  wire logic               tx_serial,
  input  wire logic [LEVEL_W-1:0] tx_level,
  input  wire logic               tx_done_evt,
  input  wire logic               tx_idle_gap_evt,
  input  wire logic               tx_null_done_evt,
  input  wire logic               flow_char_taken,
  output logic                    tx_allow,
  output logic                    flow_char_req,
  output logic      [7:0]         flow_char,
  // receiver side
  output logic                    rx_serial,
  input  wire logic [LEVEL_W-1:0] rx_level,
  input  wire logic               rx_start_evt,
  input  wire logic               rx_byte_evt,
  input  wire logic [7:0]         rx_byte,
  input  wire logic               rx_frame_err_evt,
  input  wire logic               rx_parity_err_evt,
  input  wire logic               rx_break_evt,
  input  wire logic               rx_push_full_evt,
  input  wire logic               rs485_collision_evt,
  // interrupt
  output logic                    irq
);

  // registers
  logic [CONF_W-1:0] conf_reg;
  logic [9:0]        rx_thr_reg;
  logic [9:0]        tx_thr_reg;
  logic [7:0]        xoff_thr_reg;
  logic [31:0]       chars_reg;
  logic [15:0]       tout_reg;
  logic [IRQ_N-1:0]  raw_reg;
  logic [IRQ_N-1:0]  raw_next;
  logic [IRQ_N-1:0]  ena_reg;
  logic [IRQ_N-1:0]  evt;
  logic [2:0]        sync1_reg;
  logic [2:0]        sync2_reg;
  logic              cts_prev_reg;
  logic              dsr_prev_reg;
  logic              soft_halt_reg;
  logic              xoff_pend_reg;
  logic              xon_pend_reg;
  logic              xoff_sent_reg;
  logic [7:0]        rx_count_reg;
  logic [7:0]        esc_count_reg;
  logic [15:0]       tout_cnt_reg;

  // apb decode
  wire        wr_en       = psel & penable & pwrite;
  wire        rd_en       = psel & penable & ~pwrite;
  wire        hit_conf    = paddr == OFF_CONF;
  wire        hit_cmd     = paddr == OFF_CMD;
  wire        hit_rx_thr  = paddr == OFF_RX_THR;
  wire        hit_tx_thr  = paddr == OFF_TX_THR;
  wire        hit_xoffthr = paddr == OFF_XOFF_THR;
  wire        hit_chars   = paddr == OFF_CHARS;
  wire        hit_tout    = paddr == OFF_TOUT;
  wire        hit_status  = paddr == OFF_STATUS;
  wire        hit_raw     = paddr == OFF_INT_RAW;
  wire        hit_st      = paddr == OFF_INT_ST;
  wire        hit_ena     = paddr == OFF_INT_ENA;
  wire        hit_clr     = paddr == OFF_INT_CLR;
  wire        mapped      = hit_conf | hit_cmd | hit_rx_thr | hit_tx_thr | hit_xoffthr
                          | hit_chars | hit_tout | hit_status | hit_raw | hit_st
                          | hit_ena | hit_clr;
  wire        cmd_wr      = wr_en & hit_cmd;
  wire        clr_wr      = wr_en & hit_clr;

  // configuration fields
  wire        rx_flow_en     = conf_reg[CONF_RX_FLOW_EN];
  wire        soft_request_level = conf_reg[CONF_SOFT_RTS];
  wire        loopback       = conf_reg[CONF_LOOPBACK];
  wire        tx_flow_en     = conf_reg[CONF_TX_FLOW_EN];
  wire        soft_flow_enable = conf_reg[CONF_SOFT_FLOW_EN];
  wire        rs485_en       = conf_reg[CONF_RS485_EN];
  wire [6:0]  rx_full_threshold      = rx_thr_reg[6:0];
  wire [2:0]  rx_full_threshold_high = rx_thr_reg[9:7];
  wire [9:0]  rx_full_combined = {rx_full_threshold_high, rx_full_threshold};
  wire [7:0]  xon_char       = chars_reg[7:0];
  wire [7:0]  xoff_char      = chars_reg[15:8];
  wire [7:0]  esc_char       = chars_reg[23:16];
  wire [7:0]  esc_num        = chars_reg[31:24];

  // loopback selection on synchronised pins
  wire        cts_eff  = loopback ? rts_out : sync2_reg[0];  // see [R07]
  wire        dsr_eff  = loopback ? dtr_out : sync2_reg[1];  // see [R07]
  wire        rx_pin   = sync2_reg[2];
  wire        cts_edge = cts_eff ^ cts_prev_reg;              // see [R04]
  wire        dsr_edge = dsr_eff ^ dsr_prev_reg;              // see [R05]

  // level comparisons
  wire        rx_over_thr = 10'(rx_level) > {3'h0, rx_full_threshold};   // see [R03]
  wire        rx_high     = 10'(rx_level) > rx_full_combined;            // see [R22]
  wire        tx_low      = 10'(tx_level) < tx_thr_reg;                  // see [R21]
  wire        rts_next    = rx_flow_en ? ~rx_over_thr : soft_request_level;  // see [R02]

  // received character classification
  wire        got_xon   = rx_byte_evt & soft_flow_enable & (rx_byte == xon_char);
  wire        got_xoff  = rx_byte_evt & soft_flow_enable & (rx_byte == xoff_char);
  wire        got_esc   = rx_byte_evt & (rx_byte == esc_char);
  wire        esc_done  = got_esc & (esc_count_reg + 8'h01 == esc_num);  // see [R11]
  wire        rx_count_over = rx_count_reg > xoff_thr_reg;
  wire        auto_xoff = soft_flow_enable & rx_count_over & ~xoff_sent_reg;  // see [R09]
  wire        tout_hit  = (rx_level != '0) & (tout_cnt_reg == tout_reg);     // see [R17]
  wire        take_xoff = flow_char_taken & xoff_pend_reg;
  wire        take_xon  = flow_char_taken & ~xoff_pend_reg & xon_pend_reg;

  // event vector
  always_comb begin
    evt                  = '0;
    evt[IRQ_ESCAPE]      = esc_done;                         // see [R11]
    evt[IRQ_COLLISION]   = rs485_en & rs485_collision_evt;   // see [R12]
    evt[IRQ_RS485_FRM]   = rs485_en & rx_frame_err_evt;      // see [R12]
    evt[IRQ_RS485_PAR]   = rs485_en & rx_parity_err_evt;     // see [R12]
    evt[IRQ_TX_DONE]     = tx_done_evt;                      // see [R13]
    evt[IRQ_IDLE_GAP]    = tx_idle_gap_evt;                  // see [R14]
    evt[IRQ_NULL_DONE]   = tx_null_done_evt;                 // see [R14]
    evt[IRQ_START_BIT]   = rx_start_evt;                     // see [R15]
    evt[IRQ_HALT_CHAR]   = got_xoff;                         // see [R16]
    evt[IRQ_RESUME_CHAR] = got_xon;                          // see [R16]
    evt[IRQ_RX_TIMEOUT]  = tout_hit;                         // see [R17]
    evt[IRQ_LINE_BREAK]  = rx_break_evt;                     // see [R18]
    evt[IRQ_CTS_CHG]     = cts_edge;                         // see [R04]
    evt[IRQ_DSR_CHG]     = dsr_edge;                         // see [R05]
    evt[IRQ_RX_OVF]      = rx_push_full_evt;                 // see [R19]
    evt[IRQ_FRAME_ERR]   = rx_frame_err_evt;                 // see [R20]
    evt[IRQ_PARITY_ERR]  = rx_parity_err_evt;                // see [R20]
    evt[IRQ_TX_LOW]      = tx_low;                           // see [R21]
    evt[IRQ_RX_HIGH]     = rx_high;                          // see [R22]
  end

  // set wins over a clear in the same cycle
  always_comb begin
    raw_next = raw_reg;
    if (clr_wr) begin
      raw_next = raw_reg & ~pwdata[IRQ_N-1:0];
    end
    raw_next = raw_next | evt;  // see [R23]
  end

  // pin synchronisers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
    end else begin
      sync1_reg <= {rxd_in, dsr_in, cts_in};
      sync2_reg <= sync1_reg;
    end
  end

  // pin outputs and edge history
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cts_prev_reg <= 1'b1;
      dsr_prev_reg <= 1'b1;
      rts_out      <= 1'b0;
      dtr_out      <= 1'b0;
      txd_out      <= 1'b1;
      rx_serial    <= 1'b1;
    end else begin
      cts_prev_reg <= cts_eff;
      dsr_prev_reg <= dsr_eff;
      rts_out      <= rts_next;                              // see [R01]
      dtr_out      <= conf_reg[CONF_DTR];                    // see [R06]
      txd_out      <= loopback ? 1'b1 : tx_serial;           // see [R07]
      rx_serial    <= loopback ? tx_serial : rx_pin;         // see [R07]
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conf_reg     <= CONF_RST;
      rx_thr_reg   <= RX_THR_RST;
      tx_thr_reg   <= TX_THR_RST;
      xoff_thr_reg <= XOFF_THR_RST;
      chars_reg    <= CHARS_RST;
      tout_reg     <= TOUT_RST;
      ena_reg      <= '0;
    end else begin
      if (wr_en && hit_conf)    conf_reg     <= pwdata[CONF_W-1:0];
      if (wr_en && hit_rx_thr)  rx_thr_reg   <= pwdata[9:0];
      if (wr_en && hit_tx_thr)  tx_thr_reg   <= pwdata[9:0];
      if (wr_en && hit_xoffthr) xoff_thr_reg <= pwdata[7:0];
      if (wr_en && hit_chars)   chars_reg    <= pwdata;
      if (wr_en && hit_tout)    tout_reg     <= pwdata[15:0];
      if (wr_en && hit_ena)     ena_reg      <= pwdata[IRQ_N-1:0];
    end
  end

  // raw interrupt flags
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      raw_reg <= '0;
    end else begin
      raw_reg <= raw_next;
    end
  end

  // forced halt state, on wins when both written together
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      soft_halt_reg <= 1'b0;
    end else if (cmd_wr && pwdata[CMD_FORCE_ON]) begin
      soft_halt_reg <= 1'b0;                                 // see [R08]
    end else if (cmd_wr && pwdata[CMD_FORCE_OFF]) begin
      soft_halt_reg <= 1'b1;                                 // see [R08]
    end
  end

  // flow character requests; a new request beats a take in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      xoff_pend_reg <= 1'b0;
      xon_pend_reg  <= 1'b0;
      xoff_sent_reg <= 1'b0;
    end else begin
      if ((cmd_wr && pwdata[CMD_SEND_XOFF] && soft_flow_enable) || auto_xoff) begin
        xoff_pend_reg <= 1'b1;                               // see [R09] [R10]
      end else if (take_xoff) begin
        xoff_pend_reg <= 1'b0;
      end
      if (cmd_wr && pwdata[CMD_SEND_XON] && soft_flow_enable) begin
        xon_pend_reg <= 1'b1;                                // see [R10]
      end else if (take_xon) begin
        xon_pend_reg <= 1'b0;
      end
      if (auto_xoff) begin
        xoff_sent_reg <= 1'b1;
      end else if (take_xon) begin
        xoff_sent_reg <= 1'b0;
      end
    end
  end

  // received byte count since the last resume char went out
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_count_reg <= '0;
    end else if (take_xon) begin
      rx_count_reg <= '0;
    end else if (rx_byte_evt && rx_count_reg != 8'hff) begin
      rx_count_reg <= rx_count_reg + 8'h01;
    end
  end

  // escape run counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      esc_count_reg <= '0;
    end else if (rx_byte_evt) begin
      esc_count_reg <= (got_esc && !esc_done) ? esc_count_reg + 8'h01 : 8'h00;
    end
  end

  // idle counter while receive data waits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tout_cnt_reg <= '0;
    end else if (rx_byte_evt || rx_start_evt || rx_level == '0) begin
      tout_cnt_reg <= '0;
    end else if (tout_cnt_reg != tout_reg) begin
      tout_cnt_reg <= tout_cnt_reg + 16'h0001;
    end
  end

  // transmitter steering, honoured at frame boundary
  assign tx_allow      = ~soft_halt_reg & ~(tx_flow_en & ~cts_eff);  // see [R04] [R08]
  assign flow_char_req = xoff_pend_reg | xon_pend_reg;               // see [R10]
  assign flow_char     = xoff_pend_reg ? xoff_char : xon_char;
  assign irq           = |(raw_reg & ena_reg);                       // see [R23]

  // apb read mux
  wire [31:0] status_word = {26'h0, xon_pend_reg, xoff_pend_reg, soft_halt_reg,
                             rts_out, dsr_eff, cts_eff};             // see [R05]
  wire [31:0] rd_word =
      hit_conf    ? {25'h0, conf_reg}           :
      hit_rx_thr  ? {22'h0, rx_thr_reg}         :
      hit_tx_thr  ? {22'h0, tx_thr_reg}         :
      hit_xoffthr ? {24'h0, xoff_thr_reg}       :
      hit_chars   ? chars_reg                   :
      hit_tout    ? {16'h0, tout_reg}           :
      hit_status  ? status_word                 :
      hit_raw     ? {13'h0, raw_reg}            :
      hit_st      ? {13'h0, raw_reg & ena_reg}  :
      hit_ena     ? {13'h0, ena_reg}            : 32'h0;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_word;
    end
  end

endmodule : uart_flow_control_irq
`default_nettype wire

// ### verification/uart_fc_partner.sv
`default_nettype none
module uart_fc_partner (
  // control from the bench
  input  wire logic clk,
  input  wire logic ready,
  input  wire logic slow,
  input  wire logic dsr_lvl,
  // pins of the device
  input  wire logic rts_out,
  output logic      cts_in,
  output logic      dsr_in,
  output logic      rxd_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] dly_reg = 4'hf;
  // start 0, data 8'h35 lsb first, stop 1
  logic [9:0] frm_reg = 10'h26a;
  always_ff @(posedge clk) begin
    dly_reg <= {dly_reg[2:0], ready};
    if (rts_out) frm_reg <= {frm_reg[0], frm_reg[9:1]};
  end
  assign cts_in = slow ? dly_reg[3] : dly_reg[0];
  assign dsr_in = dsr_lvl;
  assign rxd_in = rts_out ? frm_reg[0] : 1'b1;
endmodule : uart_fc_partner
`default_nettype wire

// ### verification/uart_fc_chk.sv
`default_nettype none
module uart_fc_chk
  import uart_fc_pkg::*;
#(
  parameter int LEVEL_W = 10
) (
  // clock, reset, apb
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  // pins and sides
  input wire logic               cts_in,
  input wire logic               tx_serial,
  input wire logic [LEVEL_W-1:0] tx_level,
  input wire logic [LEVEL_W-1:0] rx_level,
  input wire logic               tx_done_evt,
  input wire logic               flow_char_taken,
  input wire logic               txd_out,
  input wire logic               rts_out,
  input wire logic               dtr_out,
  input wire logic               tx_allow,
  input wire logic               flow_char_req,
  input wire logic               irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // shadow of written registers
  logic [CONF_W-1:0] conf_reg;
  logic [9:0]        rx_thr_reg;
  logic [9:0]        tx_thr_reg;
  logic [IRQ_N-1:0]  ena_reg;
  wire logic         wr_hit = psel && penable && pwrite;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conf_reg   <= CONF_RST;
      rx_thr_reg <= RX_THR_RST;
      tx_thr_reg <= TX_THR_RST;
      ena_reg    <= '0;
    end else if (wr_hit) begin
      case (paddr)
        OFF_CONF:    conf_reg   <= pwdata[CONF_W-1:0];
        OFF_RX_THR:  rx_thr_reg <= pwdata[9:0];
        OFF_TX_THR:  tx_thr_reg <= pwdata[9:0];
        OFF_INT_ENA: ena_reg    <= pwdata[IRQ_N-1:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_rts_soft_level: assert property (
    !$past(conf_reg[CONF_RX_FLOW_EN]) |-> rts_out == $past(conf_reg[CONF_SOFT_RTS]))
    else $error("rts_out not at soft level");
  a_rts_rx_thresh: assert property (
    $past(conf_reg[CONF_RX_FLOW_EN]) |-> rts_out == !($past(rx_level) > $past(rx_thr_reg[6:0])))
    else $error("rts_out wrong against rx threshold");
  a_dtr_follow: assert property (
    dtr_out == $past(conf_reg[CONF_DTR])) else $error("dtr_out wrong");
  a_txd_loop_path: assert property (
    txd_out == ($past(conf_reg[CONF_LOOPBACK]) ? 1'b1 : $past(tx_serial)))
    else $error("txd_out wrong");
  a_cts_edge_irq: assert property (
    ena_reg[IRQ_CTS_CHG] && !conf_reg[CONF_LOOPBACK] && $changed(cts_in) |-> ##[1:4] irq)
    else $error("no irq after cts edge");
  a_tx_done_irq: assert property (
    tx_done_evt && ena_reg[IRQ_TX_DONE] |=> irq) else $error("no irq after tx done");
  a_tx_low_irq: assert property (
    ena_reg[IRQ_TX_LOW] && (tx_level < tx_thr_reg) |=> irq) else $error("no tx low irq");
  a_flow_req_hold: assert property (
    flow_char_req && !flow_char_taken |=> flow_char_req) else $error("flow request dropped");
  a_irq_gated: assert property (
    ena_reg == '0 |-> !irq) else $error("irq with all enables off");
  c_flow_taken: cover property (flow_char_req && flow_char_taken);
  c_rts_drop: cover property (conf_reg[CONF_RX_FLOW_EN] && $fell(rts_out));
  c_tx_halt: cover property ($fell(tx_allow));
endmodule : uart_fc_chk

bind uart_flow_control_irq uart_fc_chk #(.LEVEL_W(LEVEL_W)) chk_i (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .cts_in(cts_in), .tx_serial(tx_serial),
  .tx_level(tx_level), .rx_level(rx_level), .tx_done_evt(tx_done_evt),
  .flow_char_taken(flow_char_taken), .txd_out(txd_out), .rts_out(rts_out),
  .dtr_out(dtr_out), .tx_allow(tx_allow), .flow_char_req(flow_char_req), .irq(irq)
);
`default_nettype wire

// ### verification/uart_flow_control_irq_tb.sv
`default_nettype none
module uart_flow_control_irq_tb
  import uart_fc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, psel, penable, pwrite, tx_serial, ready, slow, dsr_lvl, serr;
  logic        pready, pslverr, rxd_in, cts_in, dsr_in, txd_out, rts_out, dtr_out;
  logic        tx_allow, flow_char_req, rx_serial, irq;
  logic [7:0]  paddr, rx_byte, flow_char;
  logic [31:0] pwdata, prdata, rdata;
  logic [9:0]  tx_level, rx_level;
  logic [10:0] ev;
  int          fail_count = 0;
  int          checked = 0;
  logic [7:0]  rst_a[9] = '{OFF_CONF, OFF_CMD, OFF_RX_THR, OFF_TX_THR, OFF_XOFF_THR,
                            OFF_CHARS, OFF_TOUT, OFF_INT_CLR, 8'h30};
  logic [31:0] rst_v[9] = '{32'h0, 32'h0, 32'h60, 32'h10, 32'he0, 32'h032b_1311,
                            32'h100, 32'h0, 32'h0};
  logic [31:0] ev_m[9] = '{32'h10, 32'h20, 32'h40, 32'h80, 32'h8004, 32'h1_0008,
                           32'h800, 32'h4000, 32'h2};

  uart_flow_control_irq #(.LEVEL_W(10)) uut (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_in(rxd_in), .cts_in(cts_in), .dsr_in(dsr_in), .txd_out(txd_out),
    .rts_out(rts_out), .dtr_out(dtr_out), .tx_serial(tx_serial), .tx_level(tx_level),
    .tx_done_evt(ev[0]), .tx_idle_gap_evt(ev[1]), .tx_null_done_evt(ev[2]),
    .flow_char_taken(ev[10]), .tx_allow(tx_allow), .flow_char_req(flow_char_req),
    .flow_char(flow_char), .rx_serial(rx_serial), .rx_level(rx_level),
    .rx_start_evt(ev[3]), .rx_byte_evt(ev[9]), .rx_byte(rx_byte),
    .rx_frame_err_evt(ev[4]), .rx_parity_err_evt(ev[5]), .rx_break_evt(ev[6]),
    .rx_push_full_evt(ev[7]), .rs485_collision_evt(ev[8]), .irq(irq)
  );
  uart_fc_partner peer (
    .clk(clk), .ready(ready), .slow(slow), .dsr_lvl(dsr_lvl), .rts_out(rts_out),
    .cts_in(cts_in), .dsr_in(dsr_in), .rxd_in(rxd_in)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite} <= {2'b10, wr};
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    serr = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask : rd
  task automatic pulse(input int i, input logic [7:0] b);
    @(posedge clk);
    ev <= 11'h1 << i;
    rx_byte <= b;
    @(posedge clk);
    ev <= 11'h0;
  endtask : pulse
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  initial begin
    #400000;
    fail_count++;
    print_verdict();
  end
  initial begin
    {nrst, psel, penable, pwrite, slow, serr} = 6'h0;
    {tx_serial, ready, dsr_lvl} = 3'h7;
    {paddr, rx_byte, ev, rx_level} = '0;
    {pwdata, rdata} = '0;
    tx_level = 10'h010;
    w(16);
    nrst <= 1'b1;
    foreach (rst_a[i]) rd(rst_a[i], rst_v[i]);
    chk(serr, 1);
    $display("test 1 done");
    apb(1, OFF_CONF, 32'h6);
    w(2);
    chk({rts_out, dtr_out}, 2'b11);
    rd(OFF_STATUS, 32'h7);
    apb(1, OFF_RX_THR, 32'h5);
    apb(1, OFF_CONF, 32'h5);
    rx_level <= 10'd5;
    w(2);
    chk(rts_out, 1);
    rx_level <= 10'd6;
    w(2);
    chk(rts_out, 0);
    rx_level <= 10'd0;
    $display("test 2 done");
    apb(1, OFF_INT_CLR, 32'hffff_ffff);
    apb(1, OFF_INT_ENA, 32'h3000);
    apb(1, OFF_CONF, 32'h10);
    {slow, ready} <= 2'b10;
    w(10);
    chk({irq, tx_allow}, 2'b10);
    rd(OFF_INT_RAW, 32'h1000);
    apb(1, OFF_INT_CLR, 32'h1000);
    dsr_lvl <= 1'b0;
    w(6);
    rd(OFF_INT_RAW, 32'h2000);
    rd(OFF_STATUS, 32'h0);
    {slow, ready, dsr_lvl} <= 3'b011;
    w(10);
    apb(1, OFF_INT_CLR, 32'hffff_ffff);
    w(1);
    chk(irq, 0);
    $display("test 3 done");
    apb(1, OFF_CONF, 32'h40);
    apb(1, OFF_INT_ENA, 32'h7_ffff);
    for (int i = 0; i < 9; i++) begin
      pulse(i, 8'h00);
      rd(OFF_INT_ST, ev_m[i]);
      apb(1, OFF_INT_CLR, ev_m[i]);
    end
    $display("test 4 done");
    apb(1, OFF_INT_ENA, 32'h0);
    pulse(0, 8'h00);
    w(2);
    chk(irq, 0);
    apb(1, OFF_INT_ENA, 32'h2_0010);
    w(1);
    chk(irq, 1);
    apb(1, OFF_INT_CLR, 32'h10);
    w(1);
    chk(irq, 0);
    apb(1, OFF_RX_THR, 32'ha0);
    {tx_level, rx_level} <= {10'd15, 10'h61};
    w(2);
    rd(OFF_INT_RAW, 32'h2_0000);
    {tx_level, rx_level} <= {10'd16, 10'ha1};
    w(1);
    apb(1, OFF_INT_CLR, 32'hffff_ffff);
    rd(OFF_INT_RAW, 32'h4_0000);
    rx_level <= 10'd0;
    w(1);
    apb(1, OFF_INT_CLR, 32'hffff_ffff);
    $display("test 5 done");
    apb(1, OFF_CMD, 32'h1);
    w(1);
    chk(tx_allow, 0);
    rd(OFF_STATUS, 32'hb);
    apb(1, OFF_CMD, 32'h2);
    w(1);
    chk(tx_allow, 1);
    $display("test 6 done");
    apb(1, OFF_CMD, 32'h4);
    w(1);
    chk(flow_char_req, 0);
    apb(1, OFF_CONF, 32'h20);
    apb(1, OFF_XOFF_THR, 32'h3);
    for (int i = 0; i < 4; i++) begin
      chk(flow_char_req, 0);
      pulse(9, 8'h41);
    end
    w(2);
    chk({flow_char_req, flow_char}, 9'h113);
    pulse(10, 8'h00);
    w(1);
    chk(flow_char_req, 0);
    apb(1, OFF_CMD, 32'h8);
    w(1);
    chk({flow_char_req, flow_char}, 9'h111);
    pulse(10, 8'h00);
    w(1);
    chk(flow_char_req, 0);
    apb(1, OFF_INT_CLR, 32'hffff_ffff);
    pulse(9, 8'h13);
    pulse(9, 8'h11);
    rd(OFF_INT_RAW, 32'h300);
    repeat (3) pulse(9, 8'h2b);
    rd(OFF_INT_RAW, 32'h301);
    pulse(10, 8'h00);
    $display("test 7 done");
    apb(1, OFF_TOUT, 32'd20);
    pulse(9, 8'h00);
    apb(1, OFF_INT_CLR, 32'hffff_ffff);
    rx_level <= 10'd1;
    w(10);
    rd(OFF_INT_RAW, 32'h0);
    w(15);
    rd(OFF_INT_RAW, 32'h400);
    rx_level <= 10'd0;
    $display("test 8 done");
    apb(1, OFF_CONF, 32'he);
    {tx_serial, ready, dsr_lvl} <= 3'b000;
    w(5);
    chk({txd_out, rx_serial}, 2'b10);
    rd(OFF_STATUS, 32'h7);
    tx_serial <= 1'b1;
    w(3);
    chk(rx_serial, 1);
    $display("test 9 done");
    print_verdict();
  end
endmodule : uart_flow_control_irq_tb
`default_nettype wire
